// *** src/vlsm_pkg.sv ***
// Shared constants and carrier types of the velocity limit and status monitor.
// Assumes one clock domain; every user of these types imports the whole package.
package vlsm_pkg;

  // ---------------------------------------------------------------------------
  // Value ranges and defaults
  // ---------------------------------------------------------------------------
  localparam logic [15:0] DYN_LIMIT_MAX = 16'h4e20;      // 20000 mm/s.
  localparam logic [15:0] HYST_MAX      = 16'h03e8;      // 1000 mm/s.
  localparam logic [31:0] RANGE_MIN     = 32'hff676980;  // -10000000 mm.
  localparam logic [31:0] RANGE_MAX     = 32'h00989680;  // +10000000 mm.
  localparam logic [31:0] MOVE_MMS      = 32'h00000064;  // 0.1 m/s as 100 mm/s.
  localparam logic [15:0] FACTOR_MIN    = 16'h0005;
  localparam logic [15:0] FACTOR_MAX    = 16'hc350;      // 50000.
  localparam logic [15:0] FACTOR_DEF    = 16'h03e8;      // 1000.
  localparam logic [7:0]  DIST_NONE     = 8'h00;
  localparam logic [7:0]  DIST_OUTSIDE  = 8'hff;
  localparam logic [7:0]  DIST_IN_MAX   = 8'hfe;
  localparam logic [3:0]  RES_FREE_DEF  = 4'hf;          // Selector code meaning free resolution.
  localparam logic [15:0] STATUS_RST    = 16'h0001;      // Velocity error until first valid sample.

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  // Thirteen-byte dynamic limit block; byte 0 sits in the low bits.
  typedef struct packed {
    logic signed [31:0] range_end;     // Bytes 9 to 12.
    logic signed [31:0] range_start;   // Bytes 5 to 8.
    logic [15:0]        hyst;          // Bytes 3 to 4.
    logic [15:0]        limit;         // Bytes 1 to 2.
    logic [4:0]         rsv;
    logic               dir_dep;       // Bit 0.2.
    logic               below;         // Bit 0.1.
    logic               ctrl;          // Bit 0.0.
  } vlsm_dyn_s;

  // Two-byte velocity status word; bit 0.0 is the LSB.
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       dyn_act;
    logic [3:0] stat_act;
    logic       rsv_lo;
    logic       dir_neg;
    logic       moving;
    logic       dyn_exc;
    logic [3:0] stat_exc;
    logic       vel_err;
  } vlsm_status_s;

  typedef enum logic [1:0] {
    CMP_CLEAR = 2'b01,
    CMP_HIT   = 2'b10
  } vlsm_cmp_e;

endpackage

// *** src/vlsm_limit_cmp.sv ***
// Hysteresis state of one limit comparison.
// Assumes set and clear conditions come from logic on the same clock.
`timescale 1ns/1ps
module vlsm_limit_cmp
  import vlsm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  input  wire logic set_cond,
  input  wire logic clr_cond,
  output logic      hit
);

  vlsm_cmp_e state_reg;
  vlsm_cmp_e state_next;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // An inactive comparison always falls back to clear, so no stale hit survives.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CMP_CLEAR: if (en && set_cond) state_next = CMP_HIT;
      CMP_HIT:   if (clr_cond) state_next = CMP_CLEAR;
      default:   state_next = CMP_CLEAR;
    endcase
    if (!en) begin
      state_next = CMP_CLEAR;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= CMP_CLEAR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hit = (state_reg == CMP_HIT);

endmodule

// *** src/vlsm_free_scale.sv ***
// Output scaling of one measurement by a free-resolution factor.
// Assumes value, factor and selector come from logic on the same clock.
`timescale 1ns/1ps
module vlsm_free_scale
  import vlsm_pkg::*;
#(
  parameter int IN_W  = 32,
  parameter int FAC_W = 16
)(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      free,
  input  wire logic signed [IN_W-1:0]    value,
  input  wire logic [FAC_W-1:0]          factor,
  output logic signed [IN_W+FAC_W-1:0]   scaled
);

  logic [FAC_W-1:0]              fac_use;
  logic signed [IN_W+FAC_W-1:0]  scaled_reg;
  logic signed [IN_W+FAC_W-1:0]  scaled_next;

  // ---------------------------------------------------------------------------
  // Scaling
  // ---------------------------------------------------------------------------
  // Out-of-range factors are clamped rather than trusted, so a bad parameter cannot zero the output.
  always_comb begin
    fac_use = factor;
    if (factor < FACTOR_MIN) fac_use = FACTOR_MIN;
    if (factor > FACTOR_MAX) fac_use = FACTOR_MAX;
    if (free) begin
      // Both operands are widened first, so the product is formed at the full output width.
      scaled_next = (IN_W+FAC_W)'(value) * (IN_W+FAC_W)'($signed({1'b0, fac_use}));
    end else begin
      scaled_next = (IN_W+FAC_W)'(value);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      scaled_reg <= '0;
    end else begin
      scaled_reg <= scaled_next;
    end
  end

  assign scaled = scaled_reg;

  a_free_product: assert property (@(posedge clk) disable iff (rst)
    free && factor >= FACTOR_MIN && factor <= FACTOR_MAX |=> scaled == $past(value) * $signed({1'b0, $past(factor)}))
    else $error("Free scaling product is wrong.");
  a_fixed_keep: assert property (@(posedge clk) disable iff (rst)
    !free |=> scaled == (IN_W+FAC_W)'($past(value)))
    else $error("Fixed resolution value was altered.");
  a_factor_clamp: assert property (@(posedge clk) disable iff (rst)
    free && factor < FACTOR_MIN |=> scaled == $past(value) * $signed({1'b0, FACTOR_MIN}))
    else $error("Small factor not clamped.");

endmodule

// *** src/vlsm_top.sv ***
// Velocity limit and status monitor: dynamic limit check, status word,
// free-resolution scaling and reading distance report.
// Assumes all inputs come from logic on REF_CLK; the fieldbus stack unpacks the bytes.
//
// Functional notes
// - Dynamic limit values are used only while control bit 0.0 is set.
// - Bit 0.1 selects signalling on exceeding or on falling short of the limit.
// - Bit 0.2 selects direction-independent or direction-dependent comparison.
// - Velocity is compared with the unsigned 16-bit limit, up to 20000 mm/s.
// - Hysteresis up to 1000 shifts the switching point against bouncing.
// - Signed range start gives the first monitored position.
// - Signed range end gives the last monitored position; outside, no comparison.
// - Velocity status goes to the master as 2 input bytes.
// - Status bit 0.0 flags that no valid velocity exists.
// - Bits 0.1 to 0.4 show static limits 1 to 4 exceeded.
// - Bit 0.5 shows the dynamic limit condition met.
// - Bit 0.6 shows movement faster than 0.1 m/s.
// - Bit 0.7 gives direction while moving: 0 positive, 1 negative.
// - Bits 1.1 to 1.4 show static comparisons 1 to 4 active.
// - Bit 1.5 shows the dynamic comparison active.
// - Free resolution multiplies the measurement by the stored factor.
// - Only interfaces selecting free resolution are scaled.
// - Position factor is 5 to 50000, default 1000.
// - Velocity factor has the same range and default.
// - Distance is one byte in mm, 255 when outside the reading field.
// - Distance is 0 when not computable and after reset.
`timescale 1ns/1ps
module vlsm_top
  import vlsm_pkg::*;
#(
  parameter logic [3:0] RES_FREE = RES_FREE_DEF
)(
  input  wire logic               REF_CLK,
  input  wire logic               RST,
  input  wire vlsm_dyn_s          DYN_CMD,
  input  wire logic signed [31:0] VEL,
  input  wire logic               VEL_VALID,
  input  wire logic signed [31:0] POS,
  input  wire logic [3:0]         STAT_EXCEED,
  input  wire logic [3:0]         STAT_ACTIVE,
  input  wire logic [3:0]         POS_RES_SEL,
  input  wire logic [3:0]         VEL_RES_SEL,
  input  wire logic [15:0]        POS_FACTOR,
  input  wire logic [15:0]        VEL_FACTOR,
  input  wire logic [7:0]         DIST_RAW,
  input  wire logic               DIST_VALID,
  input  wire logic               DIST_IN_FIELD,
  output vlsm_status_s            STATUS,
  output logic signed [47:0]      POS_OUT,
  output logic signed [47:0]      VEL_OUT,
  output logic [7:0]              DISTANCE
);

  logic [31:0]   speed;
  logic [31:0]   mag;
  logic [15:0]   limit;
  logic [15:0]   hyst;
  logic [31:0]   lo_thr;
  logic [31:0]   hi_thr;
  logic          in_range;
  logic          dyn_en;
  logic          set_cond;
  logic          clr_cond;
  logic          dyn_hit;
  vlsm_status_s  status_reg;
  vlsm_status_s  status_next;
  logic [7:0]    dist_reg;
  logic [7:0]    dist_next;

  // ---------------------------------------------------------------------------
  // Dynamic limit qualification
  // ---------------------------------------------------------------------------
  // Velocity magnitude saturates so the most negative value cannot wrap to itself.
  always_comb begin
    mag = VEL[31] ? 32'(-VEL) : 32'(VEL);
    if (VEL == 32'sh80000000) mag = 32'h7fffffff;
    if (DYN_CMD.dir_dep) begin
      speed = VEL[31] ? 32'h00000000 : mag;
    end else begin
      speed = mag;
    end
  end

  // Limit and hysteresis beyond their documented range are clamped to its edge.
  always_comb begin
    limit = (DYN_CMD.limit > DYN_LIMIT_MAX) ? DYN_LIMIT_MAX : DYN_CMD.limit;
    hyst  = (DYN_CMD.hyst > HYST_MAX) ? HYST_MAX : DYN_CMD.hyst;
    lo_thr = (hyst > limit) ? 32'h00000000 : {16'h0000, limit - hyst};
    hi_thr = {16'h0000, limit} + {16'h0000, hyst};
  end

  // Monitoring range is inclusive at both ends.
  assign in_range = ($signed(POS) >= DYN_CMD.range_start)
                 && ($signed(POS) <= DYN_CMD.range_end);

  // Values sent with the control bit clear are simply not looked at.
  assign dyn_en = DYN_CMD.ctrl && in_range && VEL_VALID;

  // Exceed mode sets above the limit and clears at or below limit minus
  // hysteresis; below mode mirrors this around limit plus hysteresis.
  always_comb begin
    if (DYN_CMD.below) begin
      set_cond = speed < {16'h0000, limit};
      clr_cond = speed >= hi_thr;
    end else begin
      set_cond = speed > {16'h0000, limit};
      clr_cond = speed <= lo_thr;
    end
  end

  vlsm_limit_cmp u_dyn_cmp (
    .clk      (REF_CLK),
    .rst      (RST),
    .en       (dyn_en),
    .set_cond (set_cond),
    .clr_cond (clr_cond),
    .hit      (dyn_hit)
  );

  // ---------------------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------------------
  // Static limit results come from their own monitors and are only collected here.
  always_comb begin
    status_next          = '0;
    status_next.vel_err  = !VEL_VALID;
    status_next.stat_exc = STAT_EXCEED;
    status_next.stat_act = STAT_ACTIVE;
    status_next.dyn_act  = dyn_en;
    status_next.moving   = VEL_VALID && (mag > MOVE_MMS);
    status_next.dir_neg  = status_next.moving && VEL[31];
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      status_reg <= vlsm_status_s'(STATUS_RST);
    end else begin
      status_reg <= status_next;
    end
  end

  // Both sources are flip-flops; the comparator holds the hysteresis state.
  always_comb begin
    STATUS         = status_reg;
    STATUS.dyn_exc = dyn_hit;
  end

  // ---------------------------------------------------------------------------
  // Free resolution scaling
  // ---------------------------------------------------------------------------
  vlsm_free_scale #(.IN_W(32), .FAC_W(16)) u_pos_scale (
    .clk    (REF_CLK),
    .rst    (RST),
    .free   (POS_RES_SEL == RES_FREE),
    .value  (POS),
    .factor (POS_FACTOR),
    .scaled (POS_OUT)
  );

  vlsm_free_scale #(.IN_W(32), .FAC_W(16)) u_vel_scale (
    .clk    (REF_CLK),
    .rst    (RST),
    .free   (VEL_RES_SEL == RES_FREE),
    .value  (VEL),
    .factor (VEL_FACTOR),
    .scaled (VEL_OUT)
  );

  // ---------------------------------------------------------------------------
  // Reading distance
  // ---------------------------------------------------------------------------
  // An in-field reading of 255 is held at 254 so it is never mistaken for out of field.
  always_comb begin
    if (!DIST_VALID) begin
      dist_next = DIST_NONE;
    end else if (!DIST_IN_FIELD) begin
      dist_next = DIST_OUTSIDE;
    end else if (DIST_RAW > DIST_IN_MAX) begin
      dist_next = DIST_IN_MAX;
    end else begin
      dist_next = DIST_RAW;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      dist_reg <= DIST_NONE;
    end else begin
      dist_reg <= dist_next;
    end
  end

  assign DISTANCE = dist_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_ctrl_off_idle: assert property (!DYN_CMD.ctrl |=> !STATUS.dyn_act && !STATUS.dyn_exc)
    else $error("Dynamic limit acted on while control bit clear.");
  a_exceed_set: assert property (dyn_en && !DYN_CMD.below && speed > {16'h0000, limit}
    |=> STATUS.dyn_exc)
    else $error("Exceeded limit not signalled.");
  a_below_set: assert property (dyn_en && DYN_CMD.below && speed < {16'h0000, limit}
    |=> STATUS.dyn_exc)
    else $error("Short of limit not signalled.");
  a_dir_negative: assert property (dyn_en && DYN_CMD.dir_dep && !DYN_CMD.below && VEL[31]
    |=> !STATUS.dyn_exc)
    else $error("Negative travel tripped direction-dependent limit.");
  a_hyst_hold: assert property (STATUS.dyn_exc && dyn_en && !DYN_CMD.below
    && speed > lo_thr |=> STATUS.dyn_exc)
    else $error("Hit dropped inside the hysteresis band.");
  a_range_gate: assert property (!in_range |=> !STATUS.dyn_act && !STATUS.dyn_exc)
    else $error("Comparison active outside its position range.");
  // Implication keeps the first check one edge clear of reset, where the flag still holds its reset value.
  a_active_flag: assert property (1'b1 |=> STATUS.dyn_act == $past(dyn_en))
    else $error("Active flag does not follow the qualification.");
  a_vel_error: assert property (!VEL_VALID |=> STATUS.vel_err && !STATUS.moving)
    else $error("Missing velocity not flagged.");
  a_static_copy: assert property (1'b1 |=> STATUS.stat_exc == $past(STAT_EXCEED)
    && STATUS.stat_act == $past(STAT_ACTIVE))
    else $error("Static limit bits not passed on.");
  a_move_thresh: assert property (VEL_VALID && mag > MOVE_MMS |=> STATUS.moving)
    else $error("Movement above threshold not shown.");
  a_dir_moving: assert property (!STATUS.moving |-> !STATUS.dir_neg)
    else $error("Direction shown without movement.");
  a_dist_outside: assert property (DIST_VALID && !DIST_IN_FIELD |=> DISTANCE == DIST_OUTSIDE)
    else $error("Out-of-field distance not 255.");
  a_dist_none: assert property (!DIST_VALID |=> DISTANCE == DIST_NONE)
    else $error("Invalid distance not reported as 0.");

  // Release side of the hysteresis and the remaining status fields, so a broken clear path is caught too.
  a_exceed_clear: assert property (STATUS.dyn_exc && dyn_en && !DYN_CMD.below
    && speed <= lo_thr |=> !STATUS.dyn_exc)
    else $error("Exceed hit not released at the lower threshold.");
  a_below_clear: assert property (STATUS.dyn_exc && dyn_en && DYN_CMD.below
    && speed >= hi_thr |=> !STATUS.dyn_exc)
    else $error("Below hit not released at the upper threshold.");
  a_invalid_clear: assert property (!VEL_VALID |=> !STATUS.dyn_act && !STATUS.dyn_exc)
    else $error("Comparison kept without a valid velocity.");
  a_vel_ok: assert property (VEL_VALID |=> !STATUS.vel_err)
    else $error("Velocity error shown with a valid velocity.");
  a_move_still: assert property (VEL_VALID && mag <= MOVE_MMS |=> !STATUS.moving)
    else $error("Movement shown at or below the threshold.");
  a_dir_sign_neg: assert property (VEL_VALID && mag > MOVE_MMS && VEL[31] |=> STATUS.dir_neg)
    else $error("Negative travel not shown as negative.");
  a_dir_sign_pos: assert property (!VEL[31] |=> !STATUS.dir_neg)
    else $error("Positive travel shown as negative.");
  a_dist_pass: assert property (DIST_VALID && DIST_IN_FIELD && DIST_RAW <= DIST_IN_MAX
    |=> DISTANCE == $past(DIST_RAW))
    else $error("In-field distance not passed on.");

  c_exceed_then_clear: cover property (STATUS.dyn_exc ##1 !STATUS.dyn_exc && STATUS.dyn_act);
  c_below_hit: cover property (DYN_CMD.below && STATUS.dyn_exc);
  c_negative_move: cover property (STATUS.moving && STATUS.dir_neg);
  c_dist_outside: cover property (DISTANCE == DIST_OUTSIDE);
  c_dir_dep_block: cover property (DYN_CMD.dir_dep && STATUS.dyn_act && STATUS.dir_neg && !STATUS.dyn_exc);

endmodule

// *** bench/vlsm_master_model.sv ***
// Behavioural model of the fieldbus master that writes the dynamic limit output image.
// Assumes the bench changes the field values just after a falling clock edge.
`timescale 1ns/1ps
module vlsm_master_model
  import vlsm_pkg::*;
(
  input  wire logic               ctrl,
  input  wire logic               below,
  input  wire logic               dir_dep,
  input  wire logic [15:0]        limit,
  input  wire logic [15:0]        hyst,
  input  wire logic signed [31:0] rstart,
  input  wire logic signed [31:0] rend,
  output vlsm_dyn_s               dyn
);
  // ---------------------------------------------------------------------------
  // Output image
  // ---------------------------------------------------------------------------
  // The whole thirteen-byte block is sent every cycle, never a partial update.
  // Reserved bits go out as zero, as a well-behaved master would send them.
  assign dyn = {rend, rstart, hyst, limit, 5'h00, dir_dep, below, ctrl};
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench of the velocity limit and status monitor.
// Assumes the design answers every input one clock after it is sampled.
`timescale 1ns/1ps
module tb_top;
  import vlsm_pkg::*;
  logic               ref_clk;
  logic               rst;
  logic               ctrl, below, dir_dep;
  logic [15:0]        limit, hyst;
  logic signed [31:0] rstart, rend, vel, pos;
  logic               vel_valid, dist_valid, dist_in;
  logic [3:0]         stat_exceed, stat_active, pos_sel, vel_sel;
  logic [15:0]        pos_fac, vel_fac;
  logic [7:0]         dist_raw, distance;
  vlsm_dyn_s          dyn_cmd;
  vlsm_status_s       status;
  logic signed [47:0] pos_out, vel_out;
  int                 n_fail, num_checks;

  vlsm_master_model u_vlsm_master_model (.ctrl(ctrl), .below(below), .dir_dep(dir_dep), .limit(limit),
    .hyst(hyst), .rstart(rstart), .rend(rend), .dyn(dyn_cmd));

  vlsm_top u_vlsm_top (.REF_CLK(ref_clk), .RST(rst), .DYN_CMD(dyn_cmd), .VEL(vel), .VEL_VALID(vel_valid),
    .POS(pos), .STAT_EXCEED(stat_exceed), .STAT_ACTIVE(stat_active), .POS_RES_SEL(pos_sel),
    .VEL_RES_SEL(vel_sel), .POS_FACTOR(pos_fac), .VEL_FACTOR(vel_fac), .DIST_RAW(dist_raw),
    .DIST_VALID(dist_valid), .DIST_IN_FIELD(dist_in), .STATUS(status), .POS_OUT(pos_out),
    .VEL_OUT(vel_out), .DISTANCE(distance));

  // ---------------------------------------------------------------------------
  // Clock and shared tasks
  // ---------------------------------------------------------------------------
  // A 50 ns period gives the 20 MHz reference clock.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Outputs are registered, so one rising edge later they are read at the falling edge.
  task automatic step();
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Status word with the error and static fields zero.
  function automatic logic [15:0] sd(input logic da, input logic dx, input logic mv, input logic dn);
    sd = {2'b00, da, 4'h0, 1'b0, dn, mv, dx, 4'h0, 1'b0};
  endfunction

  task automatic chk_st(input string what, input logic [15:0] exp);
    num_checks++;
    if (status !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, status);
    end
  endtask

  task automatic chk_sc(input string what, input logic [47:0] exp, input logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_d(input string what, input logic [7:0] exp);
    num_checks++;
    if (distance !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, distance);
    end
  endtask

  task automatic set_dyn(input logic c, input logic b, input logic d, input logic [15:0] l,
                         input logic [15:0] h, input logic signed [31:0] s, input logic signed [31:0] e);
    ctrl = c; below = b; dir_dep = d; limit = l; hyst = h; rstart = s; rend = e;
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Exceed mode around limit 1000 with hysteresis 100, then disable and clamp.
  task automatic t_exceed();
    set_dyn(1'b1, 1'b0, 1'b0, 16'h03e8, 16'h0064, -32'sh0a, 32'sh0a);
    pos = 32'sh0; vel = 32'sh5dc; step(); chk_st("exc 1500", sd(1, 1, 1, 0));
    vel = 32'sh3b6; step(); chk_st("exc 950", sd(1, 1, 1, 0));
    vel = 32'sh384; step(); chk_st("exc 900", sd(1, 0, 1, 0));
    vel = 32'sh3e8; step(); chk_st("exc 1000", sd(1, 0, 1, 0));
    vel = 32'sh3e9; step(); chk_st("exc 1001", sd(1, 1, 1, 0));
    ctrl = 1'b0; step(); chk_st("exc ctrl off", sd(0, 0, 1, 0));
    ctrl = 1'b1; limit = 16'hffff; vel = 32'sh4e21; step();
    chk_st("exc clamp", sd(1, 1, 1, 0));
    $display("test exceed done");
  endtask

  // Below mode: condition while speed under limit, released at limit plus hysteresis.
  task automatic t_below();
    set_dyn(1'b1, 1'b1, 1'b0, 16'h03e8, 16'h0064, -32'sh0a, 32'sh0a);
    vel = 32'sh1f4; step(); chk_st("below 500", sd(1, 1, 1, 0));
    vel = 32'sh44b; step(); chk_st("below 1099", sd(1, 1, 1, 0));
    vel = 32'sh44c; step(); chk_st("below 1100", sd(1, 0, 1, 0));
    vel = 32'sh3e8; step(); chk_st("below 1000", sd(1, 0, 1, 0));
    vel = 32'sh3e7; step(); chk_st("below 999", sd(1, 1, 1, 0));
    $display("test below done");
  endtask

  // Position window edges, inclusive at both ends.
  task automatic t_range();
    set_dyn(1'b1, 1'b0, 1'b0, 16'h03e8, 16'h0064, 32'sh64, 32'shc8);
    vel = 32'sh5dc;
    pos = 32'shc9; step(); chk_st("range 201", sd(0, 0, 1, 0));
    pos = 32'shc8; step(); chk_st("range 200", sd(1, 1, 1, 0));
    pos = 32'sh64; step(); chk_st("range 100", sd(1, 1, 1, 0));
    pos = 32'sh63; step(); chk_st("range 99", sd(0, 0, 1, 0));
    $display("test range done");
  endtask

  // Direction-dependent check ignores negative travel; direction bit follows sign.
  task automatic t_dir();
    set_dyn(1'b1, 1'b0, 1'b0, 16'h03e8, 16'h0064, -32'sh0a, 32'sh0a);
    pos = 32'sh0; vel = -32'sh5dc; step(); chk_st("dir indep neg", sd(1, 1, 1, 1));
    dir_dep = 1'b1; step(); chk_st("dir dep neg", sd(1, 0, 1, 1));
    vel = 32'sh5dc; step(); chk_st("dir dep pos", sd(1, 1, 1, 0));
    $display("test direction done");
  endtask

  // Movement threshold of 100 mm/s and the invalid velocity flag.
  task automatic t_move();
    ctrl = 1'b0;
    vel = 32'sh64; step(); chk_st("move 100", sd(0, 0, 0, 0));
    vel = 32'sh65; step(); chk_st("move 101", sd(0, 0, 1, 0));
    vel = -32'sh65; step(); chk_st("move -101", sd(0, 0, 1, 1));
    vel = -32'sh64; step(); chk_st("move -100", sd(0, 0, 0, 0));
    vel_valid = 1'b0; vel = 32'sh5dc; step(); chk_st("vel invalid", 16'h0001);
    vel_valid = 1'b1;
    $display("test movement done");
  endtask

  // Static results reach their own bit positions without crossing over.
  task automatic t_static();
    vel = 32'sh0; stat_exceed = 4'ha; stat_active = 4'h5; step();
    chk_st("static a5", 16'h0a14);
    stat_exceed = 4'h5; stat_active = 4'ha; step();
    chk_st("static 5a", 16'h140a);
    stat_exceed = 4'h0; stat_active = 4'h0;
    $display("test static done");
  endtask

  // Free scaling per interface, factor range limits included.
  task automatic t_scale();
    pos = 32'sh0a; pos_sel = 4'hf; pos_fac = 16'h03e8; vel = 32'sh2; vel_sel = 4'hf; vel_fac = 16'hc350;
    step(); chk_sc("pos free", 48'h2710, pos_out);
    chk_sc("vel free", 48'h186a0, vel_out);
    pos_sel = 4'h0; vel_fac = 16'h0004; step();
    chk_sc("pos fixed", 48'h0a, pos_out);
    chk_sc("vel fac low", 48'h0a, vel_out);
    pos = -32'sh3; pos_sel = 4'hf; pos_fac = 16'h0005; vel_sel = 4'h1; step();
    chk_sc("pos neg", -48'sh0f, pos_out);
    chk_sc("vel fixed", 48'h2, vel_out);
    pos = 32'sh1; pos_fac = 16'hea60; step();
    chk_sc("pos fac high", 48'hc350, pos_out);
    $display("test scale done");
  endtask

  // Distance byte codes for no value, outside field and in field.
  task automatic t_dist();
    dist_raw = 8'h25; dist_valid = 1'b0; dist_in = 1'b1; step(); chk_d("dist none", 8'h00);
    dist_valid = 1'b1; dist_in = 1'b0; step(); chk_d("dist outside", 8'hff);
    dist_in = 1'b1; step(); chk_d("dist 37", 8'h25);
    dist_raw = 8'hff; step(); chk_d("dist in 255", 8'hfe);
    $display("test distance done");
  endtask

  // Reset in mid-run clears a held hit and the distance; the first edge after release works at once.
  task automatic t_mid_reset();
    set_dyn(1'b1, 1'b0, 1'b0, 16'h03e8, 16'h0064, -32'sh0a, 32'sh0a);
    pos = 32'sh0; vel = 32'sh5dc; dist_raw = 8'h25; dist_valid = 1'b1; dist_in = 1'b1;
    step(); chk_st("mid before", sd(1, 1, 1, 0));
    rst = 1'b1; step();
    chk_st("mid reset status", STATUS_RST);
    chk_d("mid reset dist", 8'h00);
    chk_sc("mid reset pos", 48'h0, pos_out);
    rst = 1'b0; step();
    chk_st("mid after", sd(1, 1, 1, 0));
    chk_d("mid after dist", 8'h25);
    $display("test mid reset done");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    n_fail = 0; num_checks = 0; rst = 1'b1;
    set_dyn(1'b1, 1'b0, 1'b0, 16'h03e8, 16'h0064, -32'sh0a, 32'sh0a);
    vel = 32'sh5dc; vel_valid = 1'b1; pos = 32'sh0; stat_exceed = 4'h0; stat_active = 4'h0;
    pos_sel = 4'hf; vel_sel = 4'hf; pos_fac = 16'h03e8; vel_fac = 16'h03e8;
    dist_raw = 8'h25; dist_valid = 1'b1; dist_in = 1'b0;
    repeat (20) @(negedge ref_clk);
    chk_st("reset status", STATUS_RST);
    chk_d("reset dist", 8'h00);
    chk_sc("reset pos", 48'h0, pos_out);
    rst = 1'b0;
    $display("test reset done");
    t_exceed();
    t_below();
    t_range();
    t_dir();
    t_move();
    t_static();
    t_scale();
    t_dist();
    t_mid_reset();
    end_of_test();
  end

  // A hang is cut short well inside the cycle budget.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("BAD watchdog expected finish seen none");
    end_of_test();
  end
endmodule
